// ===== verilog/cdaio_seq.sv
// Page sequencer for dwell, auxiliary I/O and subroutine pages
//
// Function
// - Dwell page halts motion for its whole seconds, any value up to 99.
// - Remaining dwell seconds shown counting down; next page runs at zero.
// - Input code zero stalls until a signal is present on that terminal.
// - Input code one stalls until that terminal's signal is removed.
// - Blank input code ignores that terminal entirely.
// - Output page energises every relay whose code is one.
// - Output page de-energises every relay whose code is zero.
// - Blank relay code keeps that relay; relay states persist between pages.
// - Call page jumps to the routine begin page with the same identifier.
// - A routine may be called repeatedly, at most 99 calls per run.
// - Identifiers over two decimal digits raise a program error.
// - Finish page returns to the page after the originating call.
// - Positioning mode at routine end stays in force after return.
`timescale 1ns/1ns
`include "cdaio_consts.svh"

module cdaio_seq #(
    parameter int unsigned SEC_CYCLES = `CDAIO_SEC_CYCLES
) (
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic                           run_start,
    output logic [`CDAIO_ADDR_W-1:0]            page_addr,
    output logic                                page_req,
    input  wire logic                           page_valid,
    input  wire cdaio_pkg::cdaio_page_kind_t    page_kind,
    input  wire logic [`CDAIO_SECS_W-1:0]       page_seconds,
    input  wire logic [2*`CDAIO_AUX_N-1:0]      page_in_codes,
    input  wire logic [2*`CDAIO_AUX_N-1:0]      page_out_codes,
    input  wire logic [`CDAIO_IDENT_W-1:0]      page_ident,
    input  wire logic                           page_abs,
    input  wire logic [`CDAIO_AUX_N-1:0]        aux_in,
    output logic [`CDAIO_AUX_N-1:0]             relay_out,
    output logic                                abs_mode,
    output logic [`CDAIO_SECS_W-1:0]            dwell_remain,
    output logic                                dwell_active,
    output logic                                input_waiting,
    output logic                                running,
    output logic                                in_routine,
    output logic [`CDAIO_CNT_W-1:0]             call_count,
    output logic                                prog_error,
    output cdaio_pkg::cdaio_err_t               error_cause
);
    import cdaio_pkg::*;

    cdaio_dwell_if dw ();

    cdaio_state_t                   state_r;
    logic [`CDAIO_ADDR_W-1:0]       addr_r;
    logic [`CDAIO_ADDR_W-1:0]       ret_r;
    logic [`CDAIO_IDENT_W-1:0]      target_r;
    logic                           in_sub_r;
    logic                           search_r;
    logic [`CDAIO_CNT_W-1:0]        calls_r;
    cdaio_page_kind_t               kind_r;
    logic [`CDAIO_SECS_W-1:0]       secs_r;
    logic [2*`CDAIO_AUX_N-1:0]      in_codes_r;
    logic [2*`CDAIO_AUX_N-1:0]      out_codes_r;
    logic [`CDAIO_IDENT_W-1:0]      ident_r;
    logic                           pg_abs_r;
    logic [`CDAIO_AUX_N-1:0]        aux_meta_r;
    logic [`CDAIO_AUX_N-1:0]        aux_sync_r;
    logic [`CDAIO_AUX_N-1:0]        relay_r;
    logic [`CDAIO_AUX_N-1:0]        relay_nxt;
    logic [`CDAIO_AUX_N-1:0]        in_ok;
    logic                           abs_r;
    logic                           err_r;
    cdaio_err_t                     cause_r;
    logic                           exec;
    logic                           err_evt;
    cdaio_err_t                     err_cause_nxt;
    logic                           found;
    logic [`CDAIO_ADDR_W-1:0]       addr_inc;

    assign exec     = (state_r == st_exec);
    assign addr_inc = addr_r + `CDAIO_ADDR_STEP;
    assign found    = (page_kind == routine_begin_page_code) && (page_ident == target_r);

    // ----------------------------------------------------------------
    // Auxiliary inputs: two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aux_meta_r <= '0;
            aux_sync_r <= '0;
        end else begin
            aux_meta_r <= aux_in;
            aux_sync_r <= aux_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // Per-terminal wait test and relay update
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CDAIO_AUX_N; gi++) begin : g_aux
            logic [`CDAIO_CODE_W-1:0] ic;
            logic [`CDAIO_CODE_W-1:0] oc;
            assign ic = in_codes_r[2*gi +: 2];
            assign oc = out_codes_r[2*gi +: 2];
            // Any code other than zero or one counts as blank
            assign in_ok[gi] = (ic == `CDAIO_CODE_ZERO) ? aux_sync_r[gi] :
                               (ic == `CDAIO_CODE_ONE)  ? !aux_sync_r[gi] :
                               1'b1;
            assign relay_nxt[gi] = (oc == `CDAIO_CODE_ONE)  ? 1'b1 :
                                   (oc == `CDAIO_CODE_ZERO) ? 1'b0 :
                                   relay_r[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Program error detection
    // ----------------------------------------------------------------
    always_comb begin
        err_evt       = 1'b0;
        err_cause_nxt = err_none;
        if (exec) begin
            case (kind_r)
                dwell_page_code: begin
                    if (secs_r > `CDAIO_MAX_SECS) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_dwell_range;
                    end
                end
                call_routine_page_code: begin
                    if (ident_r > `CDAIO_MAX_IDENT) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_ident_digits;
                    end else if (in_sub_r) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_nested_call;
                    end else if (calls_r >= `CDAIO_MAX_CALLS) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_call_limit;
                    end
                end
                routine_begin_page_code: begin
                    if (ident_r > `CDAIO_MAX_IDENT) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_ident_digits;
                    end
                end
                routine_finish_page_code: begin
                    if (!in_sub_r) begin
                        err_evt       = 1'b1;
                        err_cause_nxt = err_stray_finish;
                    end
                end
                default: begin
                end
            endcase
        end else if (state_r == st_fetch && search_r && page_valid && !found
                     && addr_r == `CDAIO_LAST_ADDR) begin
            err_evt       = 1'b1;
            err_cause_nxt = err_no_routine;
        end
    end

    // ----------------------------------------------------------------
    // Page latch
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            kind_r      <= motion_page_code;
            secs_r      <= '0;
            in_codes_r  <= '0;
            out_codes_r <= '0;
            ident_r     <= '0;
            pg_abs_r    <= `CDAIO_ABS_RST;
        end else if (state_r == st_fetch && page_valid) begin
            kind_r      <= page_kind;
            secs_r      <= page_seconds;
            in_codes_r  <= page_in_codes;
            out_codes_r <= page_out_codes;
            ident_r     <= page_ident;
            pg_abs_r    <= page_abs;
        end
    end

    // ----------------------------------------------------------------
    // Sequencing, calls and returns
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r  <= st_idle;
            addr_r   <= `CDAIO_FIRST_ADDR;
            ret_r    <= `CDAIO_FIRST_ADDR;
            target_r <= '0;
            in_sub_r <= 1'b0;
            search_r <= 1'b0;
            calls_r  <= '0;
        end else if (err_evt) begin
            state_r  <= st_error;
            search_r <= 1'b0;
        end else begin
            case (state_r)
                st_idle, st_error: begin
                    if (run_start) begin
                        state_r  <= st_fetch;
                        addr_r   <= `CDAIO_FIRST_ADDR;
                        in_sub_r <= 1'b0;
                        search_r <= 1'b0;
                        calls_r  <= '0;
                    end
                end
                st_fetch: begin
                    if (page_valid) begin
                        if (!search_r) begin
                            state_r <= st_exec;
                        end else if (found) begin
                            search_r <= 1'b0;
                            addr_r   <= addr_inc;
                        end else begin
                            addr_r <= addr_inc;
                        end
                    end
                end
                st_exec: begin
                    state_r <= st_fetch;
                    addr_r  <= addr_inc;
                    case (kind_r)
                        dwell_page_code: begin
                            if (secs_r != '0) begin
                                state_r <= st_dwell;
                                addr_r  <= addr_r;
                            end
                        end
                        input_wait_page_code: begin
                            state_r <= st_in_wait;
                            addr_r  <= addr_r;
                        end
                        call_routine_page_code: begin
                            ret_r    <= addr_inc;
                            target_r <= ident_r;
                            in_sub_r <= 1'b1;
                            search_r <= 1'b1;
                            calls_r  <= calls_r + `CDAIO_CNT_W'(1);
                            addr_r   <= `CDAIO_FIRST_ADDR;
                        end
                        routine_finish_page_code: begin
                            in_sub_r <= 1'b0;
                            addr_r   <= ret_r;
                        end
                        program_end_page_code: begin
                            state_r <= st_idle;
                            addr_r  <= addr_r;
                        end
                        default: begin
                        end
                    endcase
                end
                st_dwell: begin
                    if (dw.done) begin
                        state_r <= st_fetch;
                        addr_r  <= addr_inc;
                    end
                end
                st_in_wait: begin
                    if (&in_ok) begin
                        state_r <= st_fetch;
                        addr_r  <= addr_inc;
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Relays, positioning mode and error flag
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            relay_r <= `CDAIO_RELAY_RST;
        end else if (exec && kind_r == relay_output_page_code) begin
            relay_r <= relay_nxt;
        end
    end

    // Never restored on return, so the routine's last mode carries on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            abs_r <= `CDAIO_ABS_RST;
        end else if (exec && kind_r == motion_page_code) begin
            abs_r <= pg_abs_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_r   <= 1'b0;
            cause_r <= err_none;
        end else if (err_evt) begin
            err_r   <= 1'b1;
            cause_r <= err_cause_nxt;
        end else if (run_start && (state_r == st_idle || state_r == st_error)) begin
            err_r   <= 1'b0;
            cause_r <= err_none;
        end
    end

    // ----------------------------------------------------------------
    // Dwell timer
    // ----------------------------------------------------------------
    assign dw.start   = exec && kind_r == dwell_page_code && secs_r != '0 && !err_evt;
    assign dw.seconds = secs_r;

    cdaio_dwell_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_dwell (
        .clk    (clk),
        .resetn (resetn),
        .dw     (dw.timer)
    );

    assign page_addr     = addr_r;
    assign page_req      = (state_r == st_fetch);
    assign relay_out     = relay_r;
    assign abs_mode      = abs_r;
    assign dwell_remain  = dw.remain;
    assign dwell_active  = (state_r == st_dwell);
    assign input_waiting = (state_r == st_in_wait);
    assign running       = (state_r != st_idle) && (state_r != st_error);
    assign in_routine    = in_sub_r;
    assign call_count    = calls_r;
    assign prog_error    = err_r;
    assign error_cause   = cause_r;
endmodule

// ===== verilog/cdaio_consts.svh
// Constants of the dwell, auxiliary I/O and subroutine sequencer
`ifndef CDAIO_CONSTS_SVH
`define CDAIO_CONSTS_SVH

// ----------------------------------------------------------------
// Field widths and layout
// ----------------------------------------------------------------
`define CDAIO_ADDR_W        8
`define CDAIO_SECS_W        7
`define CDAIO_IDENT_W       10
`define CDAIO_CNT_W         7
`define CDAIO_AUX_N         4
`define CDAIO_CODE_W        2
`define CDAIO_PRESC_W       25

// ----------------------------------------------------------------
// Codes and limits
// ----------------------------------------------------------------
`define CDAIO_CODE_ZERO     2'h0
`define CDAIO_CODE_ONE      2'h1
`define CDAIO_MAX_SECS      7'h63
`define CDAIO_MAX_CALLS     7'h63
`define CDAIO_MAX_IDENT     10'h063
`define CDAIO_LAST_ADDR     8'h9f
`define CDAIO_FIRST_ADDR    8'h00
`define CDAIO_ADDR_STEP     8'h01

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CDAIO_RELAY_RST     4'h0
`define CDAIO_ABS_RST       1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CDAIO_CLK_PERIOD_NS 40
`define CDAIO_SECOND_NS     1000000000
`define CDAIO_SEC_CYCLES    (`CDAIO_SECOND_NS / `CDAIO_CLK_PERIOD_NS)

`endif

// ===== verilog/cdaio_pkg.sv
// Types of the dwell, auxiliary I/O and subroutine sequencer
package cdaio_pkg;

    typedef enum logic [2:0] {
        motion_page_code,
        dwell_page_code,
        input_wait_page_code,
        relay_output_page_code,
        call_routine_page_code,
        routine_begin_page_code,
        routine_finish_page_code,
        program_end_page_code
    } cdaio_page_kind_t;

    typedef enum logic [2:0] {
        err_none,
        err_ident_digits,
        err_nested_call,
        err_call_limit,
        err_no_routine,
        err_stray_finish,
        err_dwell_range
    } cdaio_err_t;

    typedef enum {
        st_idle,
        st_fetch,
        st_exec,
        st_dwell,
        st_in_wait,
        st_error
    } cdaio_state_t;

endpackage

// ===== verilog/cdaio_dwell_if.sv
// Link between the sequencer and its dwell timer
`timescale 1ns/1ns
`include "cdaio_consts.svh"

interface cdaio_dwell_if;
    logic                       start;
    logic [`CDAIO_SECS_W-1:0]   seconds;
    logic [`CDAIO_SECS_W-1:0]   remain;
    logic                       active;
    logic                       done;

    modport seq   (output start, output seconds, input remain, input active, input done);
    modport timer (input start, input seconds, output remain, output active, output done);
endinterface

// ===== verilog/cdaio_dwell_timer.sv
// Seconds countdown for dwell pages
`timescale 1ns/1ns
`include "cdaio_consts.svh"

module cdaio_dwell_timer #(
    parameter int unsigned SEC_CYCLES = `CDAIO_SEC_CYCLES
) (
    input  wire logic      clk,
    input  wire logic      resetn,
    cdaio_dwell_if.timer   dw
);
    import cdaio_pkg::*;

    logic [`CDAIO_PRESC_W-1:0] presc_r;
    logic [`CDAIO_SECS_W-1:0]  remain_r;
    logic                      active_r;
    logic                      done_r;
    logic                      sec_wrap;

    assign sec_wrap  = (presc_r == `CDAIO_PRESC_W'(SEC_CYCLES - 1));
    assign dw.remain = remain_r;
    assign dw.active = active_r;
    assign dw.done   = done_r;

    // ----------------------------------------------------------------
    // Countdown, one step per second
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            presc_r  <= '0;
            remain_r <= '0;
            active_r <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (dw.start) begin
                presc_r  <= '0;
                remain_r <= dw.seconds;
                active_r <= 1'b1;
            end else if (active_r) begin
                if (sec_wrap) begin
                    presc_r  <= '0;
                    remain_r <= remain_r - `CDAIO_SECS_W'(1);
                    if (remain_r == `CDAIO_SECS_W'(1)) begin
                        active_r <= 1'b0;
                        done_r   <= 1'b1;
                    end
                end else begin
                    presc_r <= presc_r + `CDAIO_PRESC_W'(1);
                end
            end
        end
    end
endmodule

// ===== bench/cdaio_seq_asserts.sv
// Assertion checker for the page sequencer
`timescale 1ns/1ns
module cdaio_seq_asserts
    import cdaio_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = 4
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       run_start,
    input wire logic       page_req,
    input wire logic [3:0] relay_out,
    input wire logic [6:0] dwell_remain,
    input wire logic       dwell_active,
    input wire logic       input_waiting,
    input wire logic       running,
    input wire logic [6:0] call_count,
    input wire logic       prog_error,
    input wire cdaio_err_t error_cause
);
    int unsigned hold_r;
    logic [6:0]  prev_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Cycles the count has stood still
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_r <= 0;
            prev_r <= 7'h00;
        end else begin
            prev_r <= dwell_remain;
            hold_r <= (!dwell_active || dwell_remain != prev_r) ? 0 : hold_r + 1;
        end
    end

    property p_start; run_start && !running |=> call_count == 7'h00 && !prog_error; endproperty
    a_start: assert property (p_start) else $error("restart not clean");
    property p_dwell_step;
        dwell_active && dwell_remain != 7'h00 |=>
            $past(dwell_remain) - dwell_remain <= 7'h01;
    endproperty
    a_dwell_step: assert property (p_dwell_step) else $error("dwell count jumped");
    property p_dwell_max; dwell_active |-> dwell_remain <= 7'h63; endproperty
    a_dwell_max: assert property (p_dwell_max) else $error("dwell above limit");
    property p_dwell_pace; dwell_active |-> hold_r < SEC_CYCLES; endproperty
    a_dwell_pace: assert property (p_dwell_pace) else $error("dwell count stalled");
    property p_dwell_halt; dwell_active |-> !page_req && !input_waiting; endproperty
    a_dwell_halt: assert property (p_dwell_halt) else $error("fetch during dwell");
    property p_wait_halt;
        input_waiting |=> (input_waiting || page_req) && $stable(relay_out);
    endproperty
    a_wait_halt: assert property (p_wait_halt) else $error("bad wait exit");
    property p_relay_idle; !running |=> $stable(relay_out); endproperty
    a_relay_idle: assert property (p_relay_idle) else $error("relay moved while idle");
    property p_err; prog_error |-> !running && error_cause != err_none; endproperty
    a_err: assert property (p_err) else $error("bad error state");
    property p_call_max; call_count <= 7'h63; endproperty
    a_call_max: assert property (p_call_max) else $error("too many calls");
    property p_call_step;
        running && !$past(run_start) && call_count != $past(call_count) |->
            call_count == $past(call_count) + 7'h01;
    endproperty
    a_call_step: assert property (p_call_step) else $error("bad call step");
endmodule

// ===== bench/cdaio_page_mem.sv
// Program page store answering the sequencer's page fetches
`timescale 1ns/1ns
module cdaio_page_mem
    import cdaio_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic [7:0]  page_addr,
    input  wire logic        page_req,
    output logic             page_valid,
    output cdaio_page_kind_t page_kind,
    output logic [6:0]       page_seconds,
    output logic [7:0]       page_in_codes,
    output logic [7:0]       page_out_codes,
    output logic [9:0]       page_ident,
    output logic             page_abs
);
    cdaio_page_kind_t kind_m [160];
    logic [9:0]       val_m  [160];
    logic [7:0]       code_m [160];
    logic             ready_r;
    logic [9:0]       noise_r;

    // Fields churn outside a fetch so a late capture is caught
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ready_r <= 1'b0;
            noise_r <= 10'h000;
        end else begin
            ready_r <= page_req && !ready_r;
            noise_r <= noise_r + 10'h1a5;
        end
    end

    assign page_valid     = page_req && (!slow || ready_r);
    assign page_kind      = page_valid ? kind_m[page_addr] : cdaio_page_kind_t'(noise_r[2:0]);
    assign page_seconds   = page_valid ? val_m[page_addr][6:0] : noise_r[6:0];
    assign page_in_codes  = page_valid ? code_m[page_addr] : noise_r[7:0];
    assign page_out_codes = page_valid ? code_m[page_addr] : ~noise_r[7:0];
    assign page_ident     = page_valid ? val_m[page_addr] : noise_r;
    assign page_abs       = page_valid ? val_m[page_addr][0] : noise_r[0];
endmodule

// ===== bench/cdaio_seq_tb.sv
// Self-checking bench for the page sequencer
`timescale 1ns/1ns
module cdaio_seq_tb;
    import cdaio_pkg::*;
    localparam int unsigned SEC_CYCLES = 4;
    logic             clk, resetn, run_start, slow, page_req, page_valid, page_abs;
    logic             abs_mode, dwell_active, input_waiting, running, in_routine, prog_error;
    logic [7:0]       page_addr, page_in_codes, page_out_codes;
    logic [6:0]       page_seconds, dwell_remain, call_count, prev;
    logic [9:0]       page_ident;
    logic [3:0]       aux_in, relay_out;
    cdaio_page_kind_t page_kind;
    cdaio_err_t       error_cause;
    int               fail_count, total_checks, n, steps;
    logic [9:0]       ev [6] = '{10'd100, 10'd99, 10'd55, 10'd100, 10'd0, 10'd7};
    cdaio_err_t       ee [6] = '{err_ident_digits, err_no_routine, err_no_routine,
                                 err_dwell_range, err_stray_finish, err_nested_call};

    cdaio_seq #(.SEC_CYCLES(SEC_CYCLES)) u_cdaio_seq (.*);
    cdaio_page_mem u_cdaio_page_mem (.*);

    always #20 clk = ~clk;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task pg(input int a, input cdaio_page_kind_t k, input logic [9:0] v,
            input logic [7:0] c);
        u_cdaio_page_mem.kind_m[a] = k;
        u_cdaio_page_mem.val_m[a] = v;
        u_cdaio_page_mem.code_m[a] = c;
    endtask

    task clr();
        for (int a = 0; a < 160; a++) pg(a, motion_page_code, 10'h001, 8'hff);
    endtask

    task run();
        @(negedge clk);
        run_start = 1'b1;
        @(negedge clk);
        run_start = 1'b0;
    endtask

    task wait_end();
        for (n = 0; n < 20000 && running; n++) @(negedge clk);
        fail_count += running;
    endtask

    task wait_dwell();
        for (n = 0; n < 50 && !dwell_active; n++) @(negedge clk);
        fail_count += !dwell_active;
    endtask

    task tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(40 * 40000);
        fail_count++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        run_start = 1'b0;
        slow = 1'b0;
        aux_in = 4'h2;
        clr();
        pg(0, relay_output_page_code, 10'h000, 8'h61);
        pg(1, dwell_page_code, 10'd99, 8'hff);
        pg(2, relay_output_page_code, 10'h000, 8'h36);
        pg(3, input_wait_page_code, 10'h000, 8'he4);
        pg(5, call_routine_page_code, 10'd7, 8'hff);
        pg(6, call_routine_page_code, 10'd7, 8'hff);
        pg(7, program_end_page_code, 10'h000, 8'hff);
        pg(8, routine_begin_page_code, 10'd8, 8'hff);
        pg(9, routine_finish_page_code, 10'h000, 8'hff);
        pg(10, routine_begin_page_code, 10'd7, 8'hff);
        pg(11, motion_page_code, 10'h000, 8'hff);
        pg(12, relay_output_page_code, 10'h000, 8'hdf);
        pg(13, routine_finish_page_code, 10'h000, 8'hff);
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        chk(relay_out, 4'h0);
        run();
        wait_dwell();
        chk(relay_out, 4'h9);
        chk(dwell_remain, 7'h63);
        prev = dwell_remain;
        for (n = 0; n < 1000 && dwell_active; n++) begin
            @(negedge clk);
            if (dwell_remain != prev) steps++;
            prev = dwell_remain;
        end
        chk(steps, 99);
        for (n = 0; n < 20 && !input_waiting; n++) @(negedge clk);
        chk(relay_out, 4'h3);
        repeat (20) @(negedge clk);
        chk(input_waiting, 1'b1);
        aux_in = 4'h3;
        repeat (10) @(negedge clk);
        chk(input_waiting, 1'b1);
        aux_in = 4'hd;
        for (n = 0; n < 10 && input_waiting; n++) @(negedge clk);
        chk(input_waiting, 1'b0);
        wait_end();
        chk(call_count, 7'h02);
        chk(relay_out, 4'h7);
        chk(abs_mode, 1'b0);
        chk(in_routine, 1'b0);
        chk(prog_error, 1'b0);
        clr();
        for (int a = 0; a < 100; a++) pg(a, call_routine_page_code, 10'd7, 8'hff);
        pg(100, program_end_page_code, 10'h000, 8'hff);
        pg(101, routine_begin_page_code, 10'd7, 8'hff);
        pg(102, routine_finish_page_code, 10'h000, 8'hff);
        run();
        wait_end();
        chk(call_count, 7'h63);
        chk(error_cause, err_call_limit);
        clr();
        pg(1, program_end_page_code, 10'h000, 8'hff);
        pg(2, routine_begin_page_code, 10'd7, 8'hff);
        pg(3, call_routine_page_code, 10'd7, 8'hff);
        slow = 1'b1;
        for (int i = 0; i < 6; i++) begin
            pg(0, i == 3 ? dwell_page_code : i == 4 ? routine_finish_page_code
                  : call_routine_page_code, ev[i], 8'hff);
            run();
            wait_end();
            chk(prog_error, 1'b1);
            chk(error_cause, ee[i]);
        end
        pg(0, relay_output_page_code, 10'h000, 8'h55);
        pg(1, dwell_page_code, 10'd5, 8'hff);
        run();
        wait_dwell();
        chk(relay_out, 4'hf);
        resetn = 1'b0;
        #5;
        chk(relay_out, 4'h0);
        chk(dwell_active, 1'b0);
        chk(running, 1'b0);
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        run();
        wait_dwell();
        chk(dwell_remain, 7'h05);
        wait_end();
        tally_and_finish();
    end
endmodule

bind cdaio_seq cdaio_seq_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_cdaio_seq_asserts (.*);
